// [logic/motor_drive_consts.svh]
// Constants for the motor drive command decoder: addresses, fields, timing
`ifndef MOTOR_DRIVE_CONSTS_SVH
`define MOTOR_DRIVE_CONSTS_SVH

// ----------------------------------------------------------------
// Command byte addresses
// ----------------------------------------------------------------
`define ADDR_MOTOR_SELECT 4'h2
`define ADDR_STEP_COUNT_LOW 4'h6
`define ADDR_STEP_COUNT_HIGH 4'h7
`define ADDR_DC_CONTROL 4'h4
`define ADDR_CC_CONTROL 4'h5

// ----------------------------------------------------------------
// Motor select codes
// ----------------------------------------------------------------
`define SEL_STEP1 3'h0
`define SEL_STEP2 3'h1
`define SEL_DC1 3'h2
`define SEL_DC2 3'h3
`define SEL_CC1 3'h4
`define SEL_CC2 3'h5
`define SEL_RESET 3'h7

// ----------------------------------------------------------------
// Field layout and scaling
// ----------------------------------------------------------------
`define STEP_HIGH_WEIGHT 17'h00100
`define DUTY_STEPS 22'h000020
`define DUTY_SHIFT 5
`define VREF_STEP_MV 10'h014
`define VREF_MIN_MV 10'h064
`define VREF_MAX_MV 10'h1f4
`define PERIOD_MAX 16'hffff

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_MHZ 200
`define RC_NOMINAL_KHZ 100
`define STEP_UNIT_US 100
`define STEP_INTERVAL_CYC (`STEP_UNIT_US * `CLK_MHZ)

`endif

// [logic/motor_drive_pkg.sv]
// Types shared by the motor drive command decoder
package motor_drive_pkg;

	typedef struct packed {
		logic [4:0] duty;
		logic brake;
		logic dir;
		logic run;
	} dc_ctrl_t;

	typedef struct packed {
		logic [4:0] level;
		logic spare;
		logic dir;
		logic en;
	} cc_ctrl_t;

	typedef struct packed {
		logic a;
		logic a_oe;
		logic b;
		logic b_oe;
	} bridge_t;

	typedef enum logic [0:0] {
		ST_IDLE,
		ST_RUN
	} step_state_t;

endpackage

// [logic/pwm_slice.sv]
// One PWM channel timed against the measured oscillator period
`timescale 1ns/1ps
module pwm_slice #(
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic period_start,
	input wire logic [WIDTH-1:0] on_cycles,
	input wire logic full_on,
	output logic pwm_on
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic on;
	} pwm_state_t;

	pwm_state_t s_q;
	pwm_state_t s_d;

	if (WIDTH < 4) begin : g_chk
		$error("pwm_slice WIDTH too small");
	end

	always_comb begin
		s_d = s_q;
		if (period_start) begin
			s_d.cnt = {{(WIDTH-1){1'b0}}, 1'b1};
			s_d.on = full_on || (on_cycles != '0);
		end else begin
			if (s_q.cnt != '1) begin
				s_d.cnt = s_q.cnt + 1'b1;
			end
			s_d.on = full_on || (s_q.cnt < on_cycles);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign pwm_on = s_q.on;
endmodule

// [logic/step_counter.sv]
// Stepper pulse counter: emits the loaded number of step pulses
`timescale 1ns/1ps
`include "motor_drive_consts.svh"
module step_counter #(
	parameter int INTERVAL_CYC = `STEP_INTERVAL_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic load,
	input wire logic [15:0] count,
	output logic step_pulse,
	output logic [2:0] phase,
	output logic busy
);
	localparam int TW = $clog2(INTERVAL_CYC + 1);

	typedef struct packed {
		motor_drive_pkg::step_state_t state;
		logic [15:0] remaining;
		logic [TW-1:0] timer;
		logic pulse;
		logic [2:0] phase;
	} step_state_s_t;

	step_state_s_t s_q;
	step_state_s_t s_d;

	if (INTERVAL_CYC < 2) begin : g_chk
		$error("step_counter INTERVAL_CYC must be at least 2");
	end

	always_comb begin
		s_d = s_q;
		s_d.pulse = 1'b0;
		case (s_q.state)
			motor_drive_pkg::ST_IDLE: begin
				if (load && count != 16'h0000) begin
					s_d.remaining = count;
					s_d.timer = TW'(INTERVAL_CYC - 1);
					s_d.state = motor_drive_pkg::ST_RUN;
				end
			end
			motor_drive_pkg::ST_RUN: begin
				if (load) begin
					s_d.remaining = count;
					s_d.timer = TW'(INTERVAL_CYC - 1);
					if (count == 16'h0000) begin
						s_d.state = motor_drive_pkg::ST_IDLE;
					end
				end else if (s_q.timer != '0) begin
					s_d.timer = s_q.timer - 1'b1;
				end else begin
					s_d.pulse = 1'b1;
					s_d.phase = s_q.phase + 3'h1;
					s_d.remaining = s_q.remaining - 16'h0001;
					s_d.timer = TW'(INTERVAL_CYC - 1);
					if (s_q.remaining == 16'h0001) begin
						s_d.state = motor_drive_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				s_d.state = motor_drive_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign step_pulse = s_q.pulse;
	assign phase = s_q.phase;
	assign busy = (s_q.state == motor_drive_pkg::ST_RUN);
endmodule

// [logic/motor_drive_command_decode.sv]
// Command byte decoder and output stage control for stepper, DC and constant-current channels
`timescale 1ns/1ps
`include "motor_drive_consts.svh"
module motor_drive_command_decode #(
	parameter int STEP_INTERVAL_CYC = `STEP_INTERVAL_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic reg_wr,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_data,
	input wire logic pwm_rc_oscillator_input,
	input wire logic [1:0] current_trip,
	output motor_drive_pkg::bridge_t [1:0] dc_bridge,
	output motor_drive_pkg::bridge_t [1:0] cc_bridge,
	output logic [1:0][9:0] cc_vref_mv,
	output logic [1:0] step_pulse,
	output logic [1:0][2:0] step_phase,
	output logic [1:0] step_busy,
	output logic [15:0] rc_period_cycles,
	output logic cmd_reject
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------
	function automatic motor_drive_pkg::bridge_t bridge_drive(
		input logic run,
		input logic dir,
		input logic on,
		input logic brake
	);
		motor_drive_pkg::bridge_t r;
		r = '0;
		if (run) begin
			r.a_oe = 1'b1;
			r.b_oe = 1'b1;
			r.a = on & ~dir;
			r.b = on & dir;
		end else if (brake) begin
			r.a = 1'b1;
			r.b = 1'b1;
			r.a_oe = 1'b1;
			r.b_oe = 1'b1;
		end
		return r;
	endfunction

	function automatic logic [15:0] duty_on_time(input logic [4:0] duty, input logic [15:0] period);
		logic [21:0] p;
		p = (22'(duty) + 22'h000001) * 22'(period);
		return p[`DUTY_SHIFT +: 16];
	endfunction

	function automatic logic [9:0] vref_decode(input logic [4:0] level);
		logic [9:0] mv;
		mv = 10'(level) * `VREF_STEP_MV;
		if (mv < `VREF_MIN_MV) begin
			mv = `VREF_MIN_MV;
		end else if (mv > `VREF_MAX_MV) begin
			mv = `VREF_MAX_MV;
		end
		return mv;
	endfunction

	function automatic logic sel_pair(input logic [2:0] sel, input logic [2:0] first);
		logic hit;
		hit = (sel == first) || (sel == first + 3'h1);
		return hit;
	endfunction

	function automatic logic sel_index(input logic [2:0] sel);
		logic idx;
		idx = sel[0];
		return idx;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic rc_meta;
		logic rc_sync;
		logic rc_prev;
		logic [1:0] trip_meta;
		logic [1:0] trip_sync;
		logic [2:0] sel;
		logic [7:0] step_low;
		logic [15:0] step_count;
		logic [1:0] step_load;
		motor_drive_pkg::dc_ctrl_t [1:0] dc;
		motor_drive_pkg::cc_ctrl_t [1:0] cc;
		logic [15:0] period_cnt;
		logic [15:0] period;
		logic [1:0] chop;
		motor_drive_pkg::bridge_t [1:0] dc_out;
		motor_drive_pkg::bridge_t [1:0] cc_out;
		logic [1:0][9:0] vref;
		logic reject;
		logic [1:0] pulse_out;
		logic [1:0][2:0] phase_out;
		logic [1:0] busy_out;
	} top_state_t;

	top_state_t s_q;
	top_state_t s_d;

	logic rc_rise;
	logic [1:0] dc_pwm;
	logic [1:0] step_pulse_w;
	logic [1:0][2:0] step_phase_w;
	logic [1:0] step_busy_w;

	assign rc_rise = s_q.rc_sync & ~s_q.rc_prev;

	if (STEP_INTERVAL_CYC < 2) begin : g_chk
		$error("STEP_INTERVAL_CYC must be at least 2");
	end

	if ((1 << `DUTY_SHIFT) != `DUTY_STEPS) begin : g_duty_chk
		$error("Duty shift does not match the duty step count");
	end

	if (`VREF_MIN_MV > `VREF_MAX_MV) begin : g_vref_chk
		$error("Reference voltage limits inverted");
	end

	if (`VREF_STEP_MV * 31 > 1023) begin : g_vref_width_chk
		$error("Reference voltage product overflows its width");
	end

	// ----------------------------------------------------------------
	// DC motor PWM slices
	// ----------------------------------------------------------------
	for (genvar i = 0; i < 2; i++) begin : g_pwm
		pwm_slice #(
			.WIDTH(16)
		) u_dc_pwm (
			.clk(clk),
			.sys_rst(sys_rst),
			.period_start(rc_rise),
			.on_cycles(duty_on_time(s_q.dc[i].duty, s_q.period)),
			.full_on(s_q.dc[i].duty == 5'h1f),
			.pwm_on(dc_pwm[i])
		);
	end

	// ----------------------------------------------------------------
	// Stepper pulse counters
	// ----------------------------------------------------------------
	for (genvar i = 0; i < 2; i++) begin : g_step
		step_counter #(
			.INTERVAL_CYC(STEP_INTERVAL_CYC)
		) u_step (
			.clk(clk),
			.sys_rst(sys_rst),
			.load(s_q.step_load[i]),
			.count(s_q.step_count),
			.step_pulse(step_pulse_w[i]),
			.phase(step_phase_w[i]),
			.busy(step_busy_w[i])
		);
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [16:0] full_count;
		full_count = '0;
		s_d = s_q;

		// ----------------------------------------------------------------
		// Two-flop synchronisers for the pins
		// ----------------------------------------------------------------
		s_d.rc_meta = pwm_rc_oscillator_input;
		s_d.rc_sync = s_q.rc_meta;
		s_d.rc_prev = s_q.rc_sync;
		s_d.trip_meta = current_trip;
		s_d.trip_sync = s_q.trip_meta;

		// ----------------------------------------------------------------
		// Oscillator period measurement
		// ----------------------------------------------------------------
		if (rc_rise) begin
			s_d.period = s_q.period_cnt;
			s_d.period_cnt = 16'h0001;
		end else if (s_q.period_cnt != `PERIOD_MAX) begin
			s_d.period_cnt = s_q.period_cnt + 16'h0001;
		end

		// ----------------------------------------------------------------
		// Command bytes
		// ----------------------------------------------------------------
		s_d.step_load = 2'b00;
		s_d.reject = 1'b0;
		if (reg_wr) begin
			case (reg_addr)
				`ADDR_MOTOR_SELECT: begin
					s_d.sel = reg_data[2:0];
				end
				`ADDR_STEP_COUNT_LOW: begin
					if (sel_pair(s_q.sel, `SEL_STEP1)) begin
						s_d.step_low = reg_data;
					end else begin
						s_d.reject = 1'b1;
					end
				end
				`ADDR_STEP_COUNT_HIGH: begin
					if (sel_pair(s_q.sel, `SEL_STEP1)) begin
						full_count = 17'(reg_data) * `STEP_HIGH_WEIGHT + 17'(s_q.step_low);
						s_d.step_count = full_count[15:0];
						s_d.step_load[sel_index(s_q.sel)] = 1'b1;
					end else begin
						s_d.reject = 1'b1;
					end
				end
				`ADDR_DC_CONTROL: begin
					if (sel_pair(s_q.sel, `SEL_DC1)) begin
						s_d.dc[sel_index(s_q.sel)] = motor_drive_pkg::dc_ctrl_t'(reg_data);
					end else begin
						s_d.reject = 1'b1;
					end
				end
				`ADDR_CC_CONTROL: begin
					if (sel_pair(s_q.sel, `SEL_CC1)) begin
						s_d.cc[sel_index(s_q.sel)] = motor_drive_pkg::cc_ctrl_t'(reg_data);
						s_d.cc[sel_index(s_q.sel)].spare = 1'b0;
					end else begin
						s_d.reject = 1'b1;
					end
				end
				default: begin
					s_d.reject = 1'b1;
				end
			endcase
		end

		// ----------------------------------------------------------------
		// Chopper latch
		// ----------------------------------------------------------------
		for (int i = 0; i < 2; i++) begin
			if (rc_rise) begin
				s_d.chop[i] = 1'b1;
			end else if (s_q.trip_sync[i]) begin
				s_d.chop[i] = 1'b0;
			end
		end

		// ----------------------------------------------------------------
		// Bridge drive and reference voltage
		// ----------------------------------------------------------------
		for (int i = 0; i < 2; i++) begin
			s_d.dc_out[i] = bridge_drive(s_q.dc[i].run, s_q.dc[i].dir, dc_pwm[i], s_q.dc[i].brake);
			s_d.cc_out[i] = bridge_drive(s_q.cc[i].en, s_q.cc[i].dir, s_q.chop[i], 1'b0);
			s_d.vref[i] = vref_decode(s_q.cc[i].level);
		end

		// ----------------------------------------------------------------
		// Stepper outputs
		// ----------------------------------------------------------------
		s_d.pulse_out = step_pulse_w;
		s_d.phase_out = step_phase_w;
		s_d.busy_out = step_busy_w;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
			s_q.sel <= `SEL_RESET;
			s_q.vref <= {`VREF_MIN_MV, `VREF_MIN_MV};
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign dc_bridge = s_q.dc_out;
	assign cc_bridge = s_q.cc_out;
	assign cc_vref_mv = s_q.vref;
	assign step_pulse = s_q.pulse_out;
	assign step_phase = s_q.phase_out;
	assign step_busy = s_q.busy_out;
	assign rc_period_cycles = s_q.period;
	assign cmd_reject = s_q.reject;
endmodule

// [test/motor_drive_properties.sv]
// Port checks for the motor drive command decoder
`timescale 1ns/1ps
module motor_drive_properties #(
	parameter int STEP_INTERVAL_CYC = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic reg_wr,
	input wire logic [3:0] reg_addr,
	input wire logic pwm_rc_oscillator_input,
	input wire motor_drive_pkg::bridge_t [1:0] dc_bridge,
	input wire motor_drive_pkg::bridge_t [1:0] cc_bridge,
	input wire logic [1:0][9:0] cc_vref_mv,
	input wire logic [1:0] step_pulse,
	input wire logic [1:0][2:0] step_phase,
	input wire logic [1:0] step_busy,
	input wire logic [15:0] rc_period_cycles,
	input wire logic cmd_reject
);
	// --------
	// Oscillator edge history
	// --------
	logic [7:0] rc_q;
	logic rc_seen;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rc_q <= 8'h00;
		end else begin
			rc_q <= {rc_q[6:0], pwm_rc_oscillator_input};
		end
	end
	assign rc_seen = |(rc_q[6:0] & ~rc_q[7:1]);
	property p_vref;
		cc_vref_mv[0] >= 10'h064 && cc_vref_mv[0] <= 10'h1f4 && cc_vref_mv[0] % 20 == 0;
	endproperty
	a_vref: assert property (p_vref) else $error("vref off grid");
	property p_vref_when;
		$changed(cc_vref_mv[0]) |-> $past(reg_wr, 2) || $past(reg_wr, 3);
	endproperty
	a_vref_when: assert property (p_vref_when) else $error("vref moved alone");
	property p_pulse;
		step_pulse[0] |-> $past(step_busy[0]);
	endproperty
	a_pulse: assert property (p_pulse) else $error("pulse while idle");
	property p_phase;
		!$past(step_busy[0]) && !step_busy[0] |-> $stable(step_phase[0]);
	endproperty
	a_phase: assert property (p_phase) else $error("idle phase moved");
	property p_busy;
		$rose(step_busy[0]) |-> $past(reg_wr, 2) || $past(reg_wr, 3) || $past(reg_wr, 4);
	endproperty
	a_busy: assert property (p_busy) else $error("busy without load");
	property p_dc_oe;
		dc_bridge[1].a_oe == dc_bridge[1].b_oe;
	endproperty
	a_dc_oe: assert property (p_dc_oe) else $error("dc half driven");
	property p_cc_oe;
		cc_bridge[0].a_oe == cc_bridge[0].b_oe;
	endproperty
	a_cc_oe: assert property (p_cc_oe) else $error("cc half driven");
	property p_rc;
		$changed(rc_period_cycles) |-> rc_seen;
	endproperty
	a_rc: assert property (p_rc) else $error("period without edge");
	property p_rej;
		reg_wr && !(reg_addr inside {4'h2, 4'h4, 4'h5, 4'h6, 4'h7}) |=> cmd_reject;
	endproperty
	a_rej: assert property (p_rej) else $error("unmapped kept");
	property p_rej_cause;
		cmd_reject |-> $past(reg_wr);
	endproperty
	a_rej_cause: assert property (p_rej_cause) else $error("reject alone");
	c_rej: cover property (cmd_reject);
	c_pulse: cover property (step_pulse[0]);
	c_brake: cover property (dc_bridge[1].a && dc_bridge[1].b);
endmodule
bind motor_drive_command_decode motor_drive_properties #(.STEP_INTERVAL_CYC(STEP_INTERVAL_CYC)) chk (
	.clk, .sys_rst, .reg_wr, .reg_addr, .pwm_rc_oscillator_input, .dc_bridge, .cc_bridge, .cc_vref_mv,
	.step_pulse, .step_phase, .step_busy, .rc_period_cycles, .cmd_reject);

// [test/motor_host.sv]
// Host controller model that loads command bytes
`timescale 1ns/1ps
module motor_host (
	input wire logic clk,
	output logic reg_wr,
	output logic [3:0] reg_addr,
	output logic [7:0] reg_data
);
	// --------
	// Byte writes
	// --------
	initial begin
		reg_wr = 1'b0;
		reg_addr = 4'h0;
		reg_data = 8'h00;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		reg_wr = 1'b1;
		reg_addr = a;
		reg_data = d;
		@(posedge clk) #1;
		reg_wr = 1'b0;
		reg_addr = ~a;
		reg_data = ~d;
	endtask
	task automatic load(input logic [2:0] s, input logic [3:0] a, input logic [7:0] d);
		wr(4'h2, {5'h00, s});
		wr(a, (a == 4'h5) ? (d & 8'hfb) : d);
	endtask
endmodule

// [test/motor_drive_command_decode_tb.sv]
// Bench for the motor drive command decoder
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; $display("Error %0t %h %h", $time, a, e); end end
module motor_drive_command_decode_tb;
	localparam int IV = 8;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic rc = 1'b0;
	logic reg_wr;
	logic [3:0] reg_addr;
	logic [7:0] reg_data;
	motor_drive_pkg::bridge_t [1:0] dc_bridge;
	motor_drive_pkg::bridge_t [1:0] cc_bridge;
	logic [1:0][9:0] cc_vref_mv;
	logic [1:0] step_pulse;
	logic [1:0][2:0] step_phase;
	logic [1:0] step_busy;
	logic cmd_reject;
	logic [1:0] trip = 2'b00;
	logic [15:0] rc_period_cycles;
	logic [4:0] codes [6] = '{5'h00, 5'h05, 5'h06, 5'h0a, 5'h19, 5'h1f};
	logic [9:0] mv [6] = '{10'h064, 10'h064, 10'h078, 10'h0c8, 10'h1f4, 10'h1f4};
	logic [7:0] dcd [4] = '{8'hf9, 8'hfb, 8'h04, 8'h00};
	logic [3:0] dce [4] = '{4'hd, 4'h7, 4'hf, 4'h0};
	logic [3:0] dcm [4] = '{4'hf, 4'hf, 4'hf, 4'h5};
	int bad_count = 0;
	int comparisons = 0;
	int n;
	always #2.5 clk = ~clk;
	initial #1 forever #62.5 rc = ~rc;
	motor_host host (.clk, .reg_wr, .reg_addr, .reg_data);
	motor_drive_command_decode #(.STEP_INTERVAL_CYC(IV)) DUT (.clk, .sys_rst, .reg_wr, .reg_addr, .reg_data,
		.pwm_rc_oscillator_input(rc), .current_trip(trip), .dc_bridge, .cc_bridge, .cc_vref_mv, .step_pulse,
		.step_phase, .step_busy, .rc_period_cycles, .cmd_reject);
	// --------
	// Tasks
	// --------
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic test_done;
		if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic steps(input int e);
		n = 0;
		cyc(4);
		for (int i = 0; i < 300 * IV && step_busy[0] !== 1'b0; i++) begin
			n += step_pulse[0];
			cyc(1);
		end
		n += step_pulse[0];
		`CHK(n, e)
	endtask
	initial begin
		#100000;
		bad_count++;
		test_done;
	end
	initial begin
		cyc(10);
		sys_rst = 1'b0;
		`CHK(cc_vref_mv[1], 10'h064)
		`CHK(dc_bridge[0].a_oe, 1'b0)
		host.wr(4'h3, 8'h01);
		`CHK(cmd_reject, 1'b1)
		host.wr(4'h4, 8'h01);
		`CHK(cmd_reject, 1'b1)
		foreach (codes[i]) begin
			host.load(3'h4, 4'h5, {codes[i], 3'h0});
			cyc(3);
			`CHK(cc_vref_mv[0], mv[i])
		end
		host.load(3'h4, 4'h5, 8'h31);
		cyc(40);
		`CHK(cc_bridge[0], 4'hd)
		trip = 2'b01;
		cyc(5);
		n = 0;
		repeat (50) begin
			n += cc_bridge[0].a;
			cyc(1);
		end
		`CHK(n, 2)
		trip = 2'b00;
		host.wr(4'h5, 8'h33);
		cyc(40);
		`CHK(cc_bridge[0], 4'h7)
		host.wr(4'h5, 8'h30);
		cyc(3);
		`CHK(cc_bridge[0] & 4'h5, 4'h0)
		foreach (dcd[i]) begin
			host.load(3'h3, 4'h4, dcd[i]);
			cyc(6);
			`CHK(dc_bridge[1] & dcm[i], dce[i])
		end
		host.load(3'h2, 4'h4, 8'h79);
		cyc(60);
		`CHK(rc_period_cycles, 16'h0019)
		n = 0;
		repeat (100) begin
			n += dc_bridge[0].a;
			cyc(1);
		end
		`CHK(n >= 46 && n <= 50, 1'b1)
		host.load(3'h0, 4'h6, 8'h03);
		host.wr(4'h7, 8'h00);
		steps(3);
		host.wr(4'h6, 8'h02);
		host.wr(4'h7, 8'h01);
		steps(258);
		host.wr(4'h6, 8'h00);
		host.wr(4'h7, 8'h00);
		steps(0);
		`CHK(step_phase[0], 3'h5)
		host.load(3'h5, 4'h5, 8'hc8);
		cyc(3);
		`CHK(cc_vref_mv[1], 10'h1f4)
		host.load(3'h1, 4'h6, 8'h01);
		host.wr(4'h7, 8'h00);
		cyc(3);
		`CHK(step_busy[1], 1'b1)
		test_done;
	end
endmodule
